// >>> src/ir_pulse_encoder.sv
// infrared transmit pulse shaper for channel 1
`default_nettype none

module ir_pulse_encoder
    import serial_pin_ctrl_pkg::*;
(
    // clock and reset
    input  wire logic         clk,
    input  wire logic         nrst,
    // bit stream from the transmitter
    input  wire logic         i_enable,
    input  wire logic         i_bit_start,
    input  wire logic         i_bit_data,
    input  wire logic         i_tick16,
    // pulse width code
    input  wire pulse_width_t i_width,
    // encoded pulse
    output logic              o_pulse
);

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_PULSE
    } enc_state_t;

    enc_state_t  state_ff;
    enc_state_t  nxt_state;
    logic [4:0]  count_ff;
    logic [4:0]  nxt_count;
    logic        pulse_ff;
    logic        nxt_pulse;

    // prohibited codes fall back to the 3/16 width so the pin never sticks high
    wire logic       use_ticks = (i_width != PW_PHI_DIV2) && (i_width != PW_PHI_DIV16);
    wire logic [4:0] length    = (i_width == PW_PHI_DIV2)  ? PULSE_CLKS_PHI2  :
                                 (i_width == PW_PHI_DIV16) ? PULSE_CLKS_PHI16 :
                                 PULSE_TICKS_3_16;
    wire logic       step      = use_ticks ? i_tick16 : 1'b1;
    wire logic       start     = i_enable && i_bit_start && !i_bit_data;

    always_comb
    begin
        nxt_state = state_ff;
        nxt_count = count_ff;
        nxt_pulse = pulse_ff;
        case (state_ff)
            ST_IDLE:
            begin
                nxt_pulse = 1'b0;
                if (start)
                begin
                    nxt_state = ST_PULSE;
                    nxt_count = length;
                    nxt_pulse = 1'b1;
                end
            end
            ST_PULSE:
            begin
                if (!i_enable)
                begin
                    nxt_state = ST_IDLE;
                    nxt_pulse = 1'b0;
                end
                else if (step)
                begin
                    nxt_count = count_ff - 5'h01;
                    if (count_ff == 5'h01)
                    begin
                        nxt_state = ST_IDLE;
                        nxt_pulse = 1'b0;
                    end
                end
            end
            default:
            begin
                nxt_state = ST_IDLE;
                nxt_pulse = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_ff <= ST_IDLE;
            count_ff <= 5'h00;
            pulse_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            count_ff <= nxt_count;
            pulse_ff <= nxt_pulse;
        end
    end

    assign o_pulse = pulse_ff;

endmodule

`default_nettype wire

// >>> src/serial_pin_ctrl_pkg.sv
// constants, register layout and encodings for the serial pin control block
// How it works
// - control register bits 7 and 6 always read one and ignore writes.
// - control bit 5 set puts channel 2 serial output on its pin, else GPIO.
// - control bit 4 set puts channel 1 serial output on its pin, else GPIO.
// - control bit 3 inverts channel 2 transmit pin data.
// - control bit 2 inverts channel 2 receive pin data before use.
// - control bit 1 inverts channel 1 transmit pin data.
// - control bit 0 inverts channel 1 receive pin data.
// - control writes act on the pins at once, mid-frame glitches possible.
// - infrared bit 7 switches channel 1 pins to infrared use.
// - infrared bits 6..4 pick pulse width: 3/16 bit, two clocks, sixteen clocks.
// - infrared bits 3..0 always read zero and ignore writes.
`default_nettype none

package serial_pin_ctrl_pkg;

    // register bus
    localparam int          ADDR_W      = 4;
    localparam int          DATA_W      = 8;
    localparam logic [3:0]  OFS_PIN_FUNC_POL = 4'h0;
    localparam logic [3:0]  OFS_IR_MODE_CTRL = 4'h1;

    // serial_pin_function_polarity field positions
    localparam int          POS_CH2_TX_PIN_SELECT = 5;
    localparam int          POS_CH1_TX_PIN_SELECT = 4;
    localparam int          POS_CH2_TX_INVERT     = 3;
    localparam int          POS_CH2_RX_INVERT     = 2;
    localparam int          POS_CH1_TX_INVERT     = 1;
    localparam int          POS_CH1_RX_INVERT     = 0;
    localparam logic [7:0]  PIN_FUNC_POL_FIXED_ONES = 8'hC0;
    localparam logic [7:0]  PIN_FUNC_POL_WR_MASK    = 8'h3F;
    localparam logic [7:0]  PIN_FUNC_POL_RESET      = 8'hC0;

    // infrared_mode_control field positions
    localparam int          POS_INFRARED_MODE_ENABLE = 7;
    localparam int          POS_PULSE_WIDTH_SEL_HI   = 6;
    localparam int          POS_PULSE_WIDTH_SEL_LO   = 4;
    localparam logic [7:0]  IR_MODE_CTRL_WR_MASK     = 8'hF0;
    localparam logic [7:0]  IR_MODE_CTRL_RESET       = 8'h00;

    // pulse width codes
    typedef enum logic [2:0] {
        PW_BIT_3_16  = 3'h0,
        PW_PHI_DIV2  = 3'h1,
        PW_RSV_2     = 3'h2,
        PW_RSV_3     = 3'h3,
        PW_PHI_DIV16 = 3'h4,
        PW_BAD_5     = 3'h5,
        PW_BAD_6     = 3'h6,
        PW_BAD_7     = 3'h7
    } pulse_width_t;

    // pulse lengths: sixteenth-bit ticks or system clocks
    localparam logic [4:0]  PULSE_TICKS_3_16   = 5'h03;
    localparam logic [4:0]  PULSE_CLKS_PHI2    = 5'h02;
    localparam logic [4:0]  PULSE_CLKS_PHI16   = 5'h10;

    // pin input synchroniser
    localparam int          SYNC_STAGES = 3;
    localparam int          N_PIN_IN    = 5;
    localparam logic [4:0]  PIN_IN_RESET = 5'h1F;

endpackage

`default_nettype wire

// >>> src/serial_pin_polarity_irda_ctrl.sv
// pin function, polarity and infrared control for two serial channels
//
// The plain strobed port and the register addresses were chosen for this implementation.
`default_nettype none

module serial_pin_polarity_irda_ctrl
(
    // clock and reset
    input  wire logic                                   I_CLK,
    input  wire logic                                   I_NRST,
    // register port
    input  wire logic [serial_pin_ctrl_pkg::ADDR_W-1:0] I_ADDR,
    input  wire logic [serial_pin_ctrl_pkg::DATA_W-1:0] I_WDATA,
    input  wire logic                                   I_WR,
    input  wire logic                                   I_RD,
    output logic      [serial_pin_ctrl_pkg::DATA_W-1:0] O_RDATA,
    // channel 1 serial core
    input  wire logic                                   I_CH1_TRANSMITTER_ENABLE,
    input  wire logic                                   I_CH1_TX_DATA,
    input  wire logic                                   I_CH1_TX_BIT_START,
    input  wire logic                                   I_CH1_TICK16,
    output logic                                        O_CH1_RX_DATA,
    // channel 2 serial core
    input  wire logic                                   I_CH2_TRANSMITTER_ENABLE,
    input  wire logic                                   I_CH2_TX_DATA,
    output logic                                        O_CH2_RX_DATA,
    // port logic behind the shared pins
    input  wire logic                                   I_GPIO_PORT3_BIT2_OUT,
    input  wire logic                                   I_GPIO_PORT3_BIT2_OE,
    output logic                                        O_GPIO_PORT3_BIT2_IN,
    input  wire logic                                   I_GPIO_PORT4_BIT2_OUT,
    input  wire logic                                   I_GPIO_PORT4_BIT2_OE,
    output logic                                        O_GPIO_PORT4_BIT2_IN,
    // channel 2 transmit pin, shared with port 3 bit 2
    input  wire logic                                   I_CH2_SERIAL_OUT_PIN,
    output logic                                        O_CH2_SERIAL_OUT_PIN,
    output logic                                        O_CH2_SERIAL_OUT_PIN_OE,
    // channel 1 transmit pin, shared with port 4 bit 2 and infrared out
    input  wire logic                                   I_CH1_SERIAL_OUT_PIN,
    output logic                                        O_CH1_SERIAL_OUT_PIN,
    output logic                                        O_CH1_SERIAL_OUT_PIN_OE,
    // receive pins
    input  wire logic                                   I_CH1_SERIAL_IN_PIN,
    input  wire logic                                   I_CH2_SERIAL_IN_PIN,
    // mode seen by the channel 1 core
    output logic                                        O_INFRARED_MODE
);

    import serial_pin_ctrl_pkg::*;

    // ------------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------------
    logic [7:0] pin_func_pol_ff;
    logic [7:0] nxt_pin_func_pol;
    logic [7:0] ir_mode_ctrl_ff;
    logic [7:0] nxt_ir_mode_ctrl;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;

    wire logic hit_pin_func = (I_ADDR == OFS_PIN_FUNC_POL);
    wire logic hit_ir_mode  = (I_ADDR == OFS_IR_MODE_CTRL);
    wire logic wr_pin_func  = I_WR && hit_pin_func;
    wire logic wr_ir_mode   = I_WR && hit_ir_mode;

    // fixed bits are rebuilt on every write rather than stored from the bus
    assign nxt_pin_func_pol = wr_pin_func ?
        ((I_WDATA & PIN_FUNC_POL_WR_MASK) | PIN_FUNC_POL_FIXED_ONES) :
        pin_func_pol_ff;
    assign nxt_ir_mode_ctrl = wr_ir_mode ?
        (I_WDATA & IR_MODE_CTRL_WR_MASK) :
        ir_mode_ctrl_ff;

    // read data valid only in the cycle after the strobe; unmapped reads zero
    wire logic [7:0] read_view_pin = pin_func_pol_ff | PIN_FUNC_POL_FIXED_ONES;
    wire logic [7:0] read_view_ir  = ir_mode_ctrl_ff & IR_MODE_CTRL_WR_MASK;
    assign nxt_rdata = !I_RD       ? 8'h00 :
                       hit_pin_func ? read_view_pin :
                       hit_ir_mode  ? read_view_ir  :
                       8'h00;

    always_ff @(posedge I_CLK or negedge I_NRST)
    begin
        if (!I_NRST)
        begin
            pin_func_pol_ff <= PIN_FUNC_POL_RESET;
            ir_mode_ctrl_ff <= IR_MODE_CTRL_RESET;
            rdata_ff        <= 8'h00;
        end
        else
        begin
            pin_func_pol_ff <= nxt_pin_func_pol;
            ir_mode_ctrl_ff <= nxt_ir_mode_ctrl;
            rdata_ff        <= nxt_rdata;
        end
    end

    // ------------------------------------------------------------------
    // decoded control fields
    // ------------------------------------------------------------------
    wire logic         ch2_tx_pin_select    = pin_func_pol_ff[POS_CH2_TX_PIN_SELECT];
    wire logic         ch1_tx_pin_select    = pin_func_pol_ff[POS_CH1_TX_PIN_SELECT];
    wire logic         ch2_tx_invert        = pin_func_pol_ff[POS_CH2_TX_INVERT];
    wire logic         ch2_rx_invert        = pin_func_pol_ff[POS_CH2_RX_INVERT];
    wire logic         ch1_tx_invert        = pin_func_pol_ff[POS_CH1_TX_INVERT];
    wire logic         ch1_rx_invert        = pin_func_pol_ff[POS_CH1_RX_INVERT];
    wire logic         infrared_mode_enable = ir_mode_ctrl_ff[POS_INFRARED_MODE_ENABLE];
    wire pulse_width_t pulse_width_sel      =
        pulse_width_t'(ir_mode_ctrl_ff[POS_PULSE_WIDTH_SEL_HI:POS_PULSE_WIDTH_SEL_LO]);

    // ------------------------------------------------------------------
    // pin input synchronisers: three stages, accept when stages 2 and 3 agree
    // ------------------------------------------------------------------
    wire logic [N_PIN_IN-1:0] pin_raw = {I_CH1_SERIAL_OUT_PIN,
                                         I_CH2_SERIAL_OUT_PIN,
                                         I_CH2_SERIAL_IN_PIN,
                                         I_CH1_SERIAL_IN_PIN,
                                         1'b1};
    logic [N_PIN_IN-1:0] pin_stable;

    genvar gi;
    generate
        for (gi = 0; gi < N_PIN_IN; gi = gi + 1)
        begin : g_sync
            logic [SYNC_STAGES-1:0] stage_ff;
            logic                   stable_ff;
            wire logic              agree = (stage_ff[1] == stage_ff[2]);

            always_ff @(posedge I_CLK or negedge I_NRST)
            begin
                if (!I_NRST)
                begin
                    stage_ff  <= {SYNC_STAGES{PIN_IN_RESET[gi]}};
                    stable_ff <= PIN_IN_RESET[gi];
                end
                else
                begin
                    stage_ff  <= {stage_ff[1:0], pin_raw[gi]};
                    stable_ff <= agree ? stage_ff[2] : stable_ff;
                end
            end

            assign pin_stable[gi] = stable_ff;
        end
    endgenerate

    wire logic ch1_in_stable     = pin_stable[1];
    wire logic ch2_in_stable     = pin_stable[2];
    wire logic ch2_outpin_stable = pin_stable[3];
    wire logic ch1_outpin_stable = pin_stable[4];

    // ------------------------------------------------------------------
    // infrared encoder on channel 1
    // ------------------------------------------------------------------
    logic ir_pulse;

    ir_pulse_encoder u_ir_enc
    (
        .clk         (I_CLK),
        .nrst        (I_NRST),
        .i_enable    (infrared_mode_enable && I_CH1_TRANSMITTER_ENABLE),
        .i_bit_start (I_CH1_TX_BIT_START),
        .i_bit_data  (I_CH1_TX_DATA),
        .i_tick16    (I_CH1_TICK16),
        .i_width     (pulse_width_sel),
        .o_pulse     (ir_pulse)
    );

    // ------------------------------------------------------------------
    // transmit pin muxing
    // ------------------------------------------------------------------
    // a disabled transmitter leaves the line at mark level
    wire logic ch2_tx_line = I_CH2_TRANSMITTER_ENABLE ? I_CH2_TX_DATA : 1'b1;
    wire logic ch1_tx_line = I_CH1_TRANSMITTER_ENABLE ? I_CH1_TX_DATA : 1'b1;

    // infrared idles low, so it replaces the whole line not just the data
    wire logic ch1_tx_coded = infrared_mode_enable ? ir_pulse : ch1_tx_line;

    // polarity is applied last so writes show on the pin straight away
    wire logic ch2_tx_pol = ch2_tx_line ^ ch2_tx_invert;
    wire logic ch1_tx_pol = ch1_tx_coded ^ ch1_tx_invert;

    // pin select chooses between serial output and port logic
    wire logic ch2_pin_val = ch2_tx_pin_select ? ch2_tx_pol : I_GPIO_PORT3_BIT2_OUT;
    wire logic ch2_pin_oe  = ch2_tx_pin_select ? 1'b1       : I_GPIO_PORT3_BIT2_OE;
    wire logic ch1_pin_val = ch1_tx_pin_select ? ch1_tx_pol : I_GPIO_PORT4_BIT2_OUT;
    wire logic ch1_pin_oe  = ch1_tx_pin_select ? 1'b1       : I_GPIO_PORT4_BIT2_OE;

    // ------------------------------------------------------------------
    // receive polarity
    // ------------------------------------------------------------------
    // infrared decode sits in the core; the pin only gets its polarity here
    wire logic ch2_rx_val = ch2_in_stable ^ ch2_rx_invert;
    wire logic ch1_rx_val = ch1_in_stable ^ ch1_rx_invert;

    // ------------------------------------------------------------------
    // output registers: one clock behind the control bits, no frame wait
    // ------------------------------------------------------------------
    logic ch2_pin_ff;
    logic ch2_pin_oe_ff;
    logic ch1_pin_ff;
    logic ch1_pin_oe_ff;
    logic ch2_rx_ff;
    logic ch1_rx_ff;
    logic gpio3_in_ff;
    logic gpio4_in_ff;
    logic ir_mode_ff;

    always_ff @(posedge I_CLK or negedge I_NRST)
    begin
        if (!I_NRST)
        begin
            ch2_pin_ff    <= 1'b1;
            ch2_pin_oe_ff <= 1'b0;
            ch1_pin_ff    <= 1'b1;
            ch1_pin_oe_ff <= 1'b0;
            ch2_rx_ff     <= 1'b1;
            ch1_rx_ff     <= 1'b1;
            gpio3_in_ff   <= 1'b1;
            gpio4_in_ff   <= 1'b1;
            ir_mode_ff    <= 1'b0;
        end
        else
        begin
            ch2_pin_ff    <= ch2_pin_val;
            ch2_pin_oe_ff <= ch2_pin_oe;
            ch1_pin_ff    <= ch1_pin_val;
            ch1_pin_oe_ff <= ch1_pin_oe;
            ch2_rx_ff     <= ch2_rx_val;
            ch1_rx_ff     <= ch1_rx_val;
            gpio3_in_ff   <= ch2_outpin_stable;
            gpio4_in_ff   <= ch1_outpin_stable;
            ir_mode_ff    <= infrared_mode_enable;
        end
    end

    assign O_RDATA                 = rdata_ff;
    assign O_CH2_SERIAL_OUT_PIN    = ch2_pin_ff;
    assign O_CH2_SERIAL_OUT_PIN_OE = ch2_pin_oe_ff;
    assign O_CH1_SERIAL_OUT_PIN    = ch1_pin_ff;
    assign O_CH1_SERIAL_OUT_PIN_OE = ch1_pin_oe_ff;
    assign O_CH2_RX_DATA           = ch2_rx_ff;
    assign O_CH1_RX_DATA           = ch1_rx_ff;
    assign O_GPIO_PORT3_BIT2_IN    = gpio3_in_ff;
    assign O_GPIO_PORT4_BIT2_IN    = gpio4_in_ff;
    assign O_INFRARED_MODE         = ir_mode_ff;

endmodule

`default_nettype wire

// >>> verification/serial_line_model.sv
// far-side line model: pulled-up transmit wires and receive drivers
`default_nettype none

module serial_line_model
(
    // transmit drives from the block
    input  wire logic i_ch1_d,
    input  wire logic i_ch1_oe,
    input  wire logic i_ch2_d,
    input  wire logic i_ch2_oe,
    // bits the far side sends
    input  wire logic i_ch1_bit,
    input  wire logic i_ch2_bit,
    // wire levels
    output logic      o_ch1_wire,
    output logic      o_ch2_wire,
    output logic      o_ch1_rx_pin,
    output logic      o_ch2_rx_pin
);
    timeunit 1ns;
    timeprecision 100ps;

    // a released wire floats up to mark through the pull-up
    assign o_ch1_wire   = i_ch1_oe ? i_ch1_d : 1'b1;
    assign o_ch2_wire   = i_ch2_oe ? i_ch2_d : 1'b1;
    assign o_ch1_rx_pin = i_ch1_bit;
    assign o_ch2_rx_pin = i_ch2_bit;
endmodule

`default_nettype wire

// >>> verification/serial_pin_chk.sv
// assertion checker for the serial pin control block
`default_nettype none

module serial_pin_chk
(
    // clock and reset
    input wire logic                                   I_CLK,
    input wire logic                                   I_NRST,
    // register port
    input wire logic [serial_pin_ctrl_pkg::ADDR_W-1:0] I_ADDR,
    input wire logic [serial_pin_ctrl_pkg::DATA_W-1:0] I_WDATA,
    input wire logic                                   I_WR,
    input wire logic                                   I_RD,
    input wire logic [serial_pin_ctrl_pkg::DATA_W-1:0] O_RDATA,
    // serial cores
    input wire logic                                   I_CH1_TRANSMITTER_ENABLE,
    input wire logic                                   I_CH1_TX_DATA,
    input wire logic                                   I_CH1_TX_BIT_START,
    input wire logic                                   I_CH2_TRANSMITTER_ENABLE,
    input wire logic                                   I_CH2_TX_DATA,
    // port logic
    input wire logic                                   I_GPIO_PORT3_BIT2_OUT,
    input wire logic                                   I_GPIO_PORT3_BIT2_OE,
    input wire logic                                   I_GPIO_PORT4_BIT2_OUT,
    input wire logic                                   I_GPIO_PORT4_BIT2_OE,
    // pins and mode
    input wire logic                                   O_CH2_SERIAL_OUT_PIN,
    input wire logic                                   O_CH2_SERIAL_OUT_PIN_OE,
    input wire logic                                   O_CH1_SERIAL_OUT_PIN,
    input wire logic                                   O_CH1_SERIAL_OUT_PIN_OE,
    input wire logic                                   O_INFRARED_MODE
);
    import serial_pin_ctrl_pkg::*;

    logic [7:0] pf_ff;
    logic [7:0] ir_ff;

    // shadow copies of both registers, built from the write strobes alone
    always_ff @(posedge I_CLK or negedge I_NRST)
    begin
        if (!I_NRST)
        begin
            pf_ff <= 8'hc0;
            ir_ff <= 8'h00;
        end
        else if (I_WR && I_ADDR == 4'h0)
            pf_ff <= I_WDATA | 8'hc0;
        else if (I_WR && I_ADDR == 4'h1)
            ir_ff <= I_WDATA & 8'hf0;
    end

    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_NRST);

    AST_RD_PIN_FUNC: assert property (I_RD && I_ADDR == 4'h0 |=> O_RDATA == pf_ff)
        else $error("pin function read data wrong");
    AST_RD_IR_CTRL: assert property (I_RD && I_ADDR == 4'h1 |=> O_RDATA == ir_ff)
        else $error("infrared control read data wrong");
    AST_RD_IDLE: assert property (!I_RD || I_ADDR > 4'h1 |=> O_RDATA == 8'h00)
        else $error("read data not zero outside a mapped read");
    // first edge after release still shows reset levels, hence the past reset term
    AST_CH2_GPIO: assert property ($past(I_NRST) && !$past(pf_ff[5]) |->
        {O_CH2_SERIAL_OUT_PIN_OE, O_CH2_SERIAL_OUT_PIN} ==
        {$past(I_GPIO_PORT3_BIT2_OE), $past(I_GPIO_PORT3_BIT2_OUT)})
        else $error("ch2 pin not following port logic");
    AST_CH2_SERIAL: assert property ($past(I_NRST) && $past(pf_ff[5]) |->
        O_CH2_SERIAL_OUT_PIN_OE && O_CH2_SERIAL_OUT_PIN == (($past(I_CH2_TRANSMITTER_ENABLE)
        ? $past(I_CH2_TX_DATA) : 1'b1) ^ $past(pf_ff[3])))
        else $error("ch2 serial pin wrong");
    AST_CH1_GPIO: assert property ($past(I_NRST) && !$past(pf_ff[4]) |->
        {O_CH1_SERIAL_OUT_PIN_OE, O_CH1_SERIAL_OUT_PIN} ==
        {$past(I_GPIO_PORT4_BIT2_OE), $past(I_GPIO_PORT4_BIT2_OUT)})
        else $error("ch1 pin not following port logic");
    AST_CH1_SERIAL: assert property ($past(I_NRST) && $past(pf_ff[4]) &&
        !$past(ir_ff[7]) |-> O_CH1_SERIAL_OUT_PIN_OE && O_CH1_SERIAL_OUT_PIN ==
        (($past(I_CH1_TRANSMITTER_ENABLE) ? $past(I_CH1_TX_DATA) : 1'b1) ^ $past(pf_ff[1])))
        else $error("ch1 serial pin wrong");
    AST_IR_MODE: assert property ($stable(ir_ff[7]) |-> O_INFRARED_MODE == ir_ff[7])
        else $error("infrared mode output wrong");
    AST_IR_PULSE: assert property (pf_ff[4] && ir_ff[7:4] == 4'h9 && !pf_ff[1] &&
        I_CH1_TRANSMITTER_ENABLE && I_CH1_TX_BIT_START && !I_CH1_TX_DATA &&
        !$past(I_CH1_TX_BIT_START) && !O_CH1_SERIAL_OUT_PIN
        |-> ##2 O_CH1_SERIAL_OUT_PIN [*2] ##1 !O_CH1_SERIAL_OUT_PIN)
        else $error("two clock infrared pulse wrong");
endmodule

bind serial_pin_polarity_irda_ctrl serial_pin_chk serial_pin_chk_i (
    .I_CLK(I_CLK), .I_NRST(I_NRST), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR),
    .I_RD(I_RD), .O_RDATA(O_RDATA), .I_CH1_TRANSMITTER_ENABLE(I_CH1_TRANSMITTER_ENABLE),
    .I_CH1_TX_DATA(I_CH1_TX_DATA), .I_CH1_TX_BIT_START(I_CH1_TX_BIT_START),
    .I_CH2_TRANSMITTER_ENABLE(I_CH2_TRANSMITTER_ENABLE), .I_CH2_TX_DATA(I_CH2_TX_DATA),
    .I_GPIO_PORT3_BIT2_OUT(I_GPIO_PORT3_BIT2_OUT), .I_GPIO_PORT3_BIT2_OE(I_GPIO_PORT3_BIT2_OE),
    .I_GPIO_PORT4_BIT2_OUT(I_GPIO_PORT4_BIT2_OUT), .I_GPIO_PORT4_BIT2_OE(I_GPIO_PORT4_BIT2_OE),
    .O_CH2_SERIAL_OUT_PIN(O_CH2_SERIAL_OUT_PIN), .O_CH2_SERIAL_OUT_PIN_OE(O_CH2_SERIAL_OUT_PIN_OE),
    .O_CH1_SERIAL_OUT_PIN(O_CH1_SERIAL_OUT_PIN), .O_CH1_SERIAL_OUT_PIN_OE(O_CH1_SERIAL_OUT_PIN_OE),
    .O_INFRARED_MODE(O_INFRARED_MODE));

`default_nettype wire

// >>> verification/tb_top.sv
// self-checking bench for the serial pin control block
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import serial_pin_ctrl_pkg::*;

    logic       clk = 1'b0;
    logic       nrst;
    logic [3:0] addr;
    logic [7:0] wdata, rdata, got;
    logic       wr, rd, en1, tx1, bst, tick, en2, tx2, g3o, g3oe, g4o, g4oe, gi3, gi4;
    logic       w1, w2, p1, p1oe, p2, p2oe, rxp1, rxp2, rxb1, rxb2, rxd1, rxd2, irm;
    logic [2:0] code [3] = '{3'h1, 3'h4, 3'h0};
    logic [7:0] wexp [3] = '{8'h02, 8'h10, 8'h0c};
    int         failures = 0;
    int         tests_run = 0;
    int         seed, n, w, v, cyc = 0;

    serial_pin_polarity_irda_ctrl serial_pin_polarity_irda_ctrl_i (
        .I_CLK(clk), .I_NRST(nrst), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
        .O_RDATA(rdata), .I_CH1_TRANSMITTER_ENABLE(en1), .I_CH1_TX_DATA(tx1),
        .I_CH1_TX_BIT_START(bst), .I_CH1_TICK16(tick), .O_CH1_RX_DATA(rxd1),
        .I_CH2_TRANSMITTER_ENABLE(en2), .I_CH2_TX_DATA(tx2), .O_CH2_RX_DATA(rxd2),
        .I_GPIO_PORT3_BIT2_OUT(g3o), .I_GPIO_PORT3_BIT2_OE(g3oe), .O_GPIO_PORT3_BIT2_IN(gi3),
        .I_GPIO_PORT4_BIT2_OUT(g4o), .I_GPIO_PORT4_BIT2_OE(g4oe), .O_GPIO_PORT4_BIT2_IN(gi4),
        .I_CH2_SERIAL_OUT_PIN(w2), .O_CH2_SERIAL_OUT_PIN(p2), .O_CH2_SERIAL_OUT_PIN_OE(p2oe),
        .I_CH1_SERIAL_OUT_PIN(w1), .O_CH1_SERIAL_OUT_PIN(p1), .O_CH1_SERIAL_OUT_PIN_OE(p1oe),
        .I_CH1_SERIAL_IN_PIN(rxp1), .I_CH2_SERIAL_IN_PIN(rxp2), .O_INFRARED_MODE(irm));

    serial_line_model serial_line_model_i (
        .i_ch1_d(p1), .i_ch1_oe(p1oe), .i_ch2_d(p2), .i_ch2_oe(p2oe), .i_ch1_bit(rxb1),
        .i_ch2_bit(rxb2), .o_ch1_wire(w1), .o_ch2_wire(w2), .o_ch1_rx_pin(rxp1),
        .o_ch2_rx_pin(rxp2));

    always #12.5 clk = ~clk;

    task automatic report_and_stop();
        if (failures == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] seen);
        tests_run++;
        if (seen !== exp)
        begin
            $display("FAIL %s expected %h seen %h", name, exp, seen);
            failures++;
        end
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    // {oe, level} a transmit pin should show
    function automatic logic [7:0] exp_pin(input logic sel, inv, en, d, go, goe);
        return 8'(sel ? {1'b1, (en ? d : 1'b1) ^ inv} : {goe, go});
    endfunction

    // one channel 1 bit with aligned ticks; counts cycles the pin is high
    task automatic ir_bit(input logic d, output int hi);
        int k;
        hi = 0;
        for (k = 0; k < 40; k++)
        begin
            @(posedge clk);
            bst <= (k == 0);
            tx1 <= d;
            tick <= (k % 4 == 0);
            #1 if (p1 === 1'b1) hi++;
        end
    endtask

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 10000)
        begin
            failures++;
            report_and_stop();
        end
    end

    initial
    begin
        seed = 32'h0000_ee56;
        {addr, wdata, wr, rd, en1, tx1, bst, tick, en2, tx2} = {4'h0, 8'h00, 8'h11};
        {g3o, g3oe, g4o, g4oe, rxb1, rxb2} = 6'h3f;
        nrst = 1'b0;
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        rd_reg(4'h0, got); chk("pin_func_reset", 8'hc0, got);
        rd_reg(4'h1, got); chk("ir_ctrl_reset", 8'h00, got);
        wr_reg(4'h0, 8'h00); rd_reg(4'h0, got); chk("pin_func_ones", 8'hc0, got);
        wr_reg(4'h1, 8'h7f); rd_reg(4'h1, got); chk("ir_ctrl_low", 8'h70, got);
        wr_reg(4'h1, 8'h00);
        for (n = 2; n < 16; n++)
        begin
            wr_reg(n[3:0], 8'hff);
            rd_reg(n[3:0], got); chk("unmapped", 8'h00, got);
        end
        rd_reg(4'h0, got); chk("pin_func_kept", 8'hc0, got);
        // select ahead of enable, then flip inversion while the line idles
        wr_reg(4'h0, 8'h20);
        en2 <= 1'b1;
        wr_reg(4'h0, 8'h28);
        #1 chk("ch2_old_level", 8'h01, 8'(p2));
        @(posedge clk);
        #1 chk("ch2_inverted", 8'h00, 8'(p2));
        for (n = 0; n < 150; n++)
        begin
            tx1 <= 1'b1;
            tx2 <= 1'b1;
            v = $random(seed);
            wr_reg(4'h0, v[7:0]);
            en1 <= v[4] & v[8];
            en2 <= v[5] & v[9];
            {tx1, tx2, g3o, g3oe, g4o, g4oe, rxb1, rxb2} <= v[17:10];
            repeat (6) @(posedge clk);
            #1 chk("pin1", exp_pin(v[4], v[1], en1, tx1, g4o, g4oe), 8'({p1oe, p1}));
            chk("pin2", exp_pin(v[5], v[3], en2, tx2, g3o, g3oe), 8'({p2oe, p2}));
            chk("gpio_in", 8'({w1, w2}), 8'({gi4, gi3}));
            chk("ch1_rx", 8'(rxb1 ^ v[0]), 8'(rxd1));
            chk("ch2_rx", 8'(rxb2 ^ v[2]), 8'(rxd2));
            rd_reg(4'h0, got); chk("pin_func_rd", v[7:0] | 8'hc0, got);
        end
        tx1 <= 1'b1;
        wr_reg(4'h0, 8'h10);
        en1 <= 1'b1;
        // only documented width codes are programmed
        for (n = 0; n < 3; n++)
        begin
            wr_reg(4'h1, {1'b1, code[n], 4'h0});
            @(posedge clk);
            #1 chk("ir_mode", 8'h01, 8'(irm));
            ir_bit(1'b0, w); chk("ir_pulse", wexp[n], 8'(w));
            ir_bit(1'b1, w); chk("ir_mark", 8'h00, 8'(w));
        end
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        #1 chk("ir_mode_reset", 8'h00, 8'(irm));
        rd_reg(4'h1, got); chk("ir_ctrl_rereset", 8'h00, got);
        report_and_stop();
    end
endmodule

`default_nettype wire
